//--- hdl/urcc_top.sv
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "urcc_cfg.svh"
module urcc_top (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic master_reset_in_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // USB lines
  input wire logic dp_i,
  input wire logic dm_i,
  // DP pull-up pin
  output logic dp_pullup_enable_out_o,
  output logic dp_pullup_enable_out_oe_o,
  // Reset outputs
  output logic system_reset_out_o,
  output logic codec_reset_out_o,
  output logic usb_serial_engine_reset_o,
  output logic usb_buffer_manager_reset_o,
  // Microcontroller side
  output logic memory_shadow_o,
  output logic irq_o
);
  import urcc_pkg::*;

  urcc_det_if det_bus ();

  logic grst_active;
  logic grst_start;
  logic usb_ev;

  // Bus reset detection
  urcc_se0_detect u_det (
    .clk_i(clk_i),
    .master_reset_in_i(master_reset_in_i),
    .rst_i(rst_i),
    .dp_i(dp_i),
    .dm_i(dm_i),
    .det(det_bus)
  );

  assign usb_ev = det_bus.usb_reset_event;

  // Global reset window
  urcc_grst_stretch u_grst (
    .clk_i(clk_i),
    .master_reset_in_i(master_reset_in_i),
    .rst_i(rst_i),
    .start_i(grst_start),
    .active_o(grst_active)
  );

  // Control and status bits
  logic bus_connect_bit, next_bus_connect_bit;
  logic memory_shadow_bit, next_memory_shadow_bit;
  logic usb_reset_global_enable, next_usb_reset_global_enable;
  logic reset_mask_bit, next_reset_mask_bit;
  logic codec_reset_ctrl_bit, next_codec_reset_ctrl_bit;
  logic usb_reset_request_flag, next_usb_reset_request_flag;

  // Bus access decode
  logic req;
  logic wr_acc;
  logic lane0;
  logic clr_flag;
  urcc_vec_t vec_out;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign lane0 = wb_sel_i[0];
  assign wr_acc = req && wb_we_i && lane0;

  // Global reset only when enabled
  assign grst_start = usb_ev && usb_reset_global_enable;

  // Vector presented while reset interrupt pending
  always_comb begin
    vec_out = `URCC_VEC_NONE;
    if (usb_reset_request_flag && reset_mask_bit
        && !usb_reset_global_enable) begin
      vec_out = `URCC_VEC_RESET;
    end
  end

  // Software clear of the request flag
  always_comb begin
    clr_flag = 1'b0;
    if (req && wb_we_i && wb_adr_i == `URCC_OFS_VEC
        && vec_out == `URCC_VEC_RESET) begin
      clr_flag = 1'b1;
    end
    if (wr_acc && wb_adr_i == `URCC_OFS_CLR
        && wb_dat_i[`URCC_BIT_FLAG]) begin
      clr_flag = 1'b1;
    end
  end

  // Next values of control and status bits
  always_comb begin
    next_bus_connect_bit = bus_connect_bit;
    next_memory_shadow_bit = memory_shadow_bit;
    next_usb_reset_global_enable = usb_reset_global_enable;
    next_reset_mask_bit = reset_mask_bit;
    next_codec_reset_ctrl_bit = codec_reset_ctrl_bit;
    next_usb_reset_request_flag = usb_reset_request_flag;
    if (wr_acc) begin
      unique case (wb_adr_i)
        `URCC_OFS_CTRL: begin
          next_bus_connect_bit = wb_dat_i[`URCC_BIT_CONN];
          next_memory_shadow_bit = wb_dat_i[`URCC_BIT_SHADOW];
          next_usb_reset_global_enable = wb_dat_i[`URCC_BIT_GEN];
        end
        `URCC_OFS_MASK: begin
          next_reset_mask_bit = wb_dat_i[`URCC_BIT_FLAG];
        end
        `URCC_OFS_CODEC: begin
          next_codec_reset_ctrl_bit = wb_dat_i[`URCC_BIT_CODEC_RESET_CTRL_BIT];
        end
        default: begin
        end
      endcase
    end
    if (clr_flag) begin
      next_usb_reset_request_flag = 1'b0;
    end
    // Set wins over a software clear
    if (usb_ev) begin
      next_usb_reset_request_flag = 1'b1;
    end
    // Global reset spares connect, shadow and enable
    if (grst_active) begin
      next_usb_reset_request_flag = 1'b0;
      next_reset_mask_bit = `URCC_RST_MASK;
      next_codec_reset_ctrl_bit = `URCC_RST_CODEC_RESET_CTRL_BIT;
    end
  end

  // Bits kept through USB resets
  always_ff @(posedge clk_i or posedge master_reset_in_i) begin
    if (master_reset_in_i) begin
      bus_connect_bit <= `URCC_RST_CONN;
      memory_shadow_bit <= `URCC_RST_SHADOW;
      usb_reset_global_enable <= `URCC_RST_GEN;
    end else if (rst_i) begin
      bus_connect_bit <= `URCC_RST_CONN;
      memory_shadow_bit <= `URCC_RST_SHADOW;
      usb_reset_global_enable <= `URCC_RST_GEN;
    end else begin
      bus_connect_bit <= next_bus_connect_bit;
      memory_shadow_bit <= next_memory_shadow_bit;
      usb_reset_global_enable <= next_usb_reset_global_enable;
    end
  end

  // Bits cleared by a global reset
  always_ff @(posedge clk_i or posedge master_reset_in_i) begin
    if (master_reset_in_i) begin
      reset_mask_bit <= `URCC_RST_MASK;
      codec_reset_ctrl_bit <= `URCC_RST_CODEC_RESET_CTRL_BIT;
      usb_reset_request_flag <= 1'b0;
    end else if (rst_i) begin
      reset_mask_bit <= `URCC_RST_MASK;
      codec_reset_ctrl_bit <= `URCC_RST_CODEC_RESET_CTRL_BIT;
      usb_reset_request_flag <= 1'b0;
    end else begin
      reset_mask_bit <= next_reset_mask_bit;
      codec_reset_ctrl_bit <= next_codec_reset_ctrl_bit;
      usb_reset_request_flag <= next_usb_reset_request_flag;
    end
  end

  // Wishbone read data and acknowledge
  logic [31:0] next_wb_dat;
  logic next_wb_ack;
  always_comb begin
    next_wb_ack = req;
    next_wb_dat = 32'h00000000;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `URCC_OFS_CTRL: begin
          next_wb_dat[`URCC_BIT_CONN] = bus_connect_bit;
          next_wb_dat[`URCC_BIT_SHADOW] = memory_shadow_bit;
          next_wb_dat[`URCC_BIT_GEN] = usb_reset_global_enable;
        end
        `URCC_OFS_STAT: begin
          next_wb_dat[`URCC_BIT_FLAG] = usb_reset_request_flag;
          next_wb_dat[`URCC_BIT_SE0] = det_bus.se0_active;
        end
        `URCC_OFS_MASK: next_wb_dat[`URCC_BIT_FLAG] = reset_mask_bit;
        `URCC_OFS_VEC: next_wb_dat[7:0] = vec_out;
        `URCC_OFS_CODEC: begin
          next_wb_dat[`URCC_BIT_CODEC_RESET_CTRL_BIT] = codec_reset_ctrl_bit;
        end
        default: next_wb_dat = 32'h00000000;
      endcase
    end
  end

  // Pin and output next values
  logic next_sysrst;
  logic next_engine_rst;
  logic next_irq;
  always_comb begin
    next_sysrst = rst_i || grst_active;
    next_engine_rst = det_bus.se0_active || grst_active;
    next_irq = usb_reset_request_flag && reset_mask_bit
               && !usb_reset_global_enable;
  end

  // Output registers
  always_ff @(posedge clk_i or posedge master_reset_in_i) begin
    if (master_reset_in_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      dp_pullup_enable_out_o <= 1'b0;
      dp_pullup_enable_out_oe_o <= 1'b0;
      system_reset_out_o <= 1'b1;
      codec_reset_out_o <= 1'b1;
      usb_serial_engine_reset_o <= 1'b1;
      usb_buffer_manager_reset_o <= 1'b1;
      memory_shadow_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      wb_ack_o <= next_wb_ack;
      wb_dat_o <= next_wb_dat;
      dp_pullup_enable_out_o <= bus_connect_bit;
      dp_pullup_enable_out_oe_o <= bus_connect_bit;
      system_reset_out_o <= next_sysrst;
      codec_reset_out_o <= !codec_reset_ctrl_bit;
      usb_serial_engine_reset_o <= next_engine_rst || rst_i;
      usb_buffer_manager_reset_o <= next_engine_rst || rst_i;
      memory_shadow_o <= memory_shadow_bit;
      irq_o <= next_irq;
    end
  end

  chk_pullup_follows_connect: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    $rose(bus_connect_bit) |=> dp_pullup_enable_out_oe_o
                               && dp_pullup_enable_out_o)
    else $error("pull-up not enabled after connect");

  chk_keep_through_reset: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    (grst_active && !wr_acc) |=> $stable({bus_connect_bit,
      memory_shadow_bit, usb_reset_global_enable}))
    else $error("kept bits changed by global reset");

  chk_flag_on_reset: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    (usb_ev && !grst_active) |=> usb_reset_request_flag)
    else $error("request flag not set on bus reset");

  chk_global_clears_flag: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    grst_start |=> ##1 !usb_reset_request_flag)
    else $error("global reset left request flag set");

  chk_no_irq_global: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    $past(usb_reset_global_enable) |-> !irq_o)
    else $error("interrupt raised in global mode");

  chk_irq_when_masked: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    (usb_reset_request_flag && reset_mask_bit
     && !usb_reset_global_enable) |=> irq_o)
    else $error("masked bus reset did not interrupt");

  chk_vector_clear: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    (clr_flag && !usb_ev) |=> !usb_reset_request_flag)
    else $error("vector write did not clear flag");

  chk_sysrst_global: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    grst_start |-> ##2 system_reset_out_o [*8])
    else $error("system reset missing for global reset");

  chk_engine_only: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    (usb_ev && !usb_reset_global_enable && !grst_active) |=>
      (usb_serial_engine_reset_o && !system_reset_out_o))
    else $error("engine-only reset misrouted");

  chk_codec_follow: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    (wr_acc && wb_adr_i == `URCC_OFS_CODEC && !grst_active) |=>
      ##1 (codec_reset_out_o == !$past(wb_dat_i[`URCC_BIT_CODEC_RESET_CTRL_BIT], 2)))
    else $error("codec reset does not follow its bit");
endmodule
`default_nettype wire

//--- hdl/urcc_cfg.svh
`ifndef URCC_CFG_SVH
`define URCC_CFG_SVH

// Register byte offsets
`define URCC_OFS_CTRL 8'h00
`define URCC_OFS_STAT 8'h04
`define URCC_OFS_MASK 8'h08
`define URCC_OFS_CLR 8'h0C
`define URCC_OFS_VEC 8'h10
`define URCC_OFS_CODEC 8'h14

// Field positions
`define URCC_BIT_CONN 0
`define URCC_BIT_SHADOW 1
`define URCC_BIT_GEN 2
`define URCC_BIT_FLAG 0
`define URCC_BIT_SE0 1
`define URCC_BIT_CODEC_RESET_CTRL_BIT 0

// Interrupt vector codes
`define URCC_VEC_RESET 8'h17
`define URCC_VEC_NONE 8'h00

// Reset values
`define URCC_RST_CONN 1'b0
`define URCC_RST_SHADOW 1'b0
`define URCC_RST_GEN 1'b0
`define URCC_RST_MASK 1'b0
`define URCC_RST_CODEC_RESET_CTRL_BIT 1'b0

// Timing
`define URCC_CLK_MHZ 40
`define URCC_SE0_MIN_NS 2500
`define URCC_SE0_MIN_CYC ((`URCC_SE0_MIN_NS * `URCC_CLK_MHZ + 999) / 1000)
`define URCC_SE0_CNT_W 8
`define URCC_GRST_CYC 16
`define URCC_GRST_CNT_W 5

`endif

//--- hdl/urcc_pkg.sv
package urcc_pkg;
  // Bus reset detector states
  typedef enum logic [1:0] {DET_IDLE, DET_COUNT, DET_HELD} urcc_det_state_t;
  // Interrupt vector value
  typedef logic [7:0] urcc_vec_t;
endpackage

//--- hdl/urcc_det_if.sv
`timescale 1ns/1ps
`default_nettype none
interface urcc_det_if;
  logic usb_reset_event;
  logic se0_active;
  modport det (output usb_reset_event, output se0_active);
  modport ctl (input usb_reset_event, input se0_active);
endinterface
`default_nettype wire

//--- hdl/urcc_se0_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "urcc_cfg.svh"
module urcc_se0_detect (
  // Clock and resets
  input wire logic clk_i,
  input wire logic master_reset_in_i,
  input wire logic rst_i,
  // USB line levels
  input wire logic dp_i,
  input wire logic dm_i,
  // Detection results
  urcc_det_if.det det
);
  import urcc_pkg::*;
  localparam int W = `URCC_SE0_CNT_W;
  localparam logic [W-1:0] SE0_LAST = W'(`URCC_SE0_MIN_CYC - 1);
  localparam logic [W-1:0] CNT_ONE = W'(1);

  logic [1:0] sync1;
  logic [1:0] sync2;
  logic se0;
  urcc_det_state_t state, next_state;
  logic [W-1:0] cnt, next_cnt;
  logic event_q, next_event;

  // Two-flop line synchroniser
  always_ff @(posedge clk_i or posedge master_reset_in_i) begin
    if (master_reset_in_i) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
    end else begin
      sync1 <= {dp_i, dm_i};
      sync2 <= sync1;
    end
  end
  assign se0 = (sync2 == 2'h0);

  // Count consecutive single-ended zero cycles
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_event = 1'b0;
    unique case (state)
      DET_IDLE: begin
        if (se0) begin
          next_state = DET_COUNT;
          next_cnt = CNT_ONE;
        end
      end
      DET_COUNT: begin
        if (!se0) begin
          next_state = DET_IDLE;
        end else if (cnt == SE0_LAST) begin
          next_state = DET_HELD;
          next_event = 1'b1;
        end else begin
          next_cnt = cnt + CNT_ONE;
        end
      end
      DET_HELD: begin
        if (!se0) begin
          next_state = DET_IDLE;
        end
      end
      default: next_state = DET_IDLE;
    endcase
  end

  // Detector state registers
  always_ff @(posedge clk_i or posedge master_reset_in_i) begin
    if (master_reset_in_i) begin
      state <= DET_IDLE;
      cnt <= '0;
      event_q <= 1'b0;
    end else if (rst_i) begin
      state <= DET_IDLE;
      cnt <= '0;
      event_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      event_q <= next_event;
    end
  end

  assign det.usb_reset_event = event_q;
  assign det.se0_active = (state == DET_HELD);

  // Helper: run length of SE0 for checking
  logic [W-1:0] run;
  always_ff @(posedge clk_i or posedge master_reset_in_i) begin
    if (master_reset_in_i) begin
      run <= '0;
    end else if (!se0) begin
      run <= '0;
    end else if (run != {W{1'b1}}) begin
      run <= run + CNT_ONE;
    end
  end

  chk_se0_min_time: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    $rose(event_q) |-> ($past(run) >= SE0_LAST))
    else $error("bus reset flagged before minimum SE0 time");
endmodule
`default_nettype wire

//--- hdl/urcc_grst_stretch.sv
`timescale 1ns/1ps
`default_nettype none
`include "urcc_cfg.svh"
module urcc_grst_stretch (
  // Clock and resets
  input wire logic clk_i,
  input wire logic master_reset_in_i,
  input wire logic rst_i,
  // Trigger and window
  input wire logic start_i,
  output logic active_o
);
  import urcc_pkg::*;
  localparam int W = `URCC_GRST_CNT_W;
  localparam logic [W-1:0] LEN = W'(`URCC_GRST_CYC);
  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] cnt, next_cnt;

  // Load on trigger, count down to zero
  always_comb begin
    next_cnt = cnt;
    if (start_i) begin
      next_cnt = LEN;
    end else if (cnt != '0) begin
      next_cnt = cnt - ONE;
    end
  end

  // Window counter register
  always_ff @(posedge clk_i or posedge master_reset_in_i) begin
    if (master_reset_in_i) begin
      cnt <= '0;
    end else if (rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign active_o = (cnt != '0);

  chk_window_length: assert property (
    @(posedge clk_i) disable iff (master_reset_in_i || rst_i)
    start_i |=> active_o [*8])
    else $error("global reset window too short");
endmodule
`default_nettype wire

//--- sim/urcc_usb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module urcc_usb_host_model (
  // Clock and command
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [15:0] len_i,
  // USB line levels
  output logic dp_o,
  output logic dm_o
);
  logic [15:0] left = 16'h0000;
  // Counts down the cycles of reset signalling
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      left <= len_i;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end
  // Idle J state, or both lines low while signalling a reset
  assign dp_o = (left == 16'h0000);
  assign dm_o = 1'b0;
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "urcc_cfg.svh"
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic master_reset_in_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, dp, dm, pu, pu_oe, sys_rst, codec_rst, eng_rst, buf_rst;
  logic shadow, irq_o, se0_go = 1'b0;
  logic [15:0] se0_len = 16'h0000;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int s, q, e;

  // Clock at 40 MHz
  always #12.5 clk_i = ~clk_i;

  urcc_usb_host_model host (.clk_i(clk_i), .go_i(se0_go), .len_i(se0_len),
    .dp_o(dp), .dm_o(dm));

  urcc_top DUT (.clk_i(clk_i), .rst_i(rst_i),
    .master_reset_in_i(master_reset_in_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dp_i(dp), .dm_i(dm),
    .dp_pullup_enable_out_o(pu), .dp_pullup_enable_out_oe_o(pu_oe),
    .system_reset_out_o(sys_rst), .codec_reset_out_o(codec_rst),
    .usb_serial_engine_reset_o(eng_rst),
    .usb_buffer_manager_reset_o(buf_rst), .memory_shadow_o(shadow),
    .irq_o(irq_o));

  // Single comparison point
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Classic single Wishbone cycle; reads note their expectation
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] x);
    if (!we) exp_q.push_back(x);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Bus reset of n cycles; counts reset, interrupt and engine cycles
  task automatic se0(input int n, output int sy, output int ir, output int en);
    sy = 0;
    ir = 0;
    en = 0;
    se0_len <= n[15:0];
    se0_go <= 1'b1;
    @(posedge clk_i);
    se0_go <= 1'b0;
    repeat (n + 40) begin
      @(posedge clk_i);
      sy += int'(sys_rst === 1'b1);
      ir += int'(irq_o === 1'b1);
      en += int'(eng_rst === 1'b1 && buf_rst === 1'b1);
    end
  endtask

  // Read data watcher takes the oldest note on each read answer
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) check("unexpected_read", 32'h1, 32'h0);
      else check("read_data", wb_dat_o, exp_q.pop_front());
    end
  end

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(33));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // Outputs seen here were launched one edge after release
    repeat (2) @(posedge clk_i);
    check("pullup_oe", pu_oe, 0);
    check("codec_rst", codec_rst, 1);
    check("sys_rst", sys_rst, 0);
    xfer(0, `URCC_OFS_CTRL, 0, 0);
    xfer(0, 8'h20, 0, 0);
    xfer(1, `URCC_OFS_CODEC, 1, 0);
    check("codec_rst", codec_rst, 0);
    xfer(1, `URCC_OFS_CODEC, 0, 0);
    check("codec_rst", codec_rst, 1);
    xfer(1, `URCC_OFS_CODEC, 1, 0);
    xfer(1, `URCC_OFS_CTRL, 3, 0);
    check("pullup", {pu, pu_oe}, 3);
    check("shadow", shadow, 1);
    // Too short to count as a bus reset
    repeat (3) begin
      se0(20 + int'($urandom % 70), s, q, e);
      xfer(0, `URCC_OFS_STAT, 0, 0);
    end
    // Neither global nor masked: only engine and buffers reset
    se0(130, s, q, e);
    check("sys_cycles", s, 0);
    check("irq_cycles", q, 0);
    check("eng_seen", 32'(e > 0), 1);
    check("codec_rst", codec_rst, 0);
    xfer(0, `URCC_OFS_STAT, 0, 1);
    xfer(0, `URCC_OFS_VEC, 0, `URCC_VEC_NONE);
    xfer(1, `URCC_OFS_CLR, 1, 0);
    xfer(0, `URCC_OFS_STAT, 0, 0);
    // Interrupt mode
    xfer(1, `URCC_OFS_MASK, 1, 0);
    se0(130, s, q, e);
    check("sys_cycles", s, 0);
    check("irq", irq_o, 1);
    xfer(0, `URCC_OFS_STAT, 0, 1);
    xfer(0, `URCC_OFS_VEC, 0, `URCC_VEC_RESET);
    xfer(1, `URCC_OFS_VEC, $urandom, 0);
    check("irq", irq_o, 0);
    xfer(0, `URCC_OFS_STAT, 0, 0);
    check("pullup", {pu, pu_oe}, 3);
    // Global mode
    xfer(1, `URCC_OFS_CTRL, 7, 0);
    se0(130, s, q, e);
    check("sys_cycles", s, `URCC_GRST_CYC);
    check("irq_cycles", q, 0);
    xfer(0, `URCC_OFS_CTRL, 0, 7);
    xfer(0, `URCC_OFS_STAT, 0, 0);
    xfer(0, `URCC_OFS_MASK, 0, 0);
    check("pullup", {pu, pu_oe, shadow}, 7);
    check("codec_rst", codec_rst, 1);
    // Master reset acts without waiting for a clock edge
    master_reset_in_i <= 1'b1;
    #1;
    check("sys_rst", sys_rst, 1);
    check("pullup", {pu_oe, shadow}, 0);
    @(posedge clk_i);
    repeat (40) @(posedge clk_i);
    master_reset_in_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("sys_rst", sys_rst, 0);
    xfer(0, `URCC_OFS_CTRL, 0, 0);
    repeat (4) @(posedge clk_i);
    print_verdict();
  end
endmodule
`default_nettype wire
